/* File: hdl/mssq_pkg.sv */
/*
 * package for the multi-segment position sequencer: register map, field
 * layouts, reset values, run modes, states and timing counts.
 * assumes a 20 MHz clock and an avalon-mm slave with 32-bit data.
 */
package mssq_pkg;

	// ------------------------------------------------------------
	// register byte addresses
	// ------------------------------------------------------------
	localparam logic [7:0] MSSQ_ADDR_RUN_MODE  = 8'h00;
	localparam logic [7:0] MSSQ_ADDR_LAST_SEG  = 8'h04;
	localparam logic [7:0] MSSQ_ADDR_RESUME    = 8'h08;
	localparam logic [7:0] MSSQ_ADDR_TIME_UNIT = 8'h0C;
	localparam logic [7:0] MSSQ_ADDR_WAIT      = 8'h10;
	localparam logic [7:0] MSSQ_ADDR_ACCEL     = 8'h14;
	localparam logic [7:0] MSSQ_ADDR_DECEL     = 8'h18;
	localparam logic [7:0] MSSQ_ADDR_STATUS    = 8'h1C;

	// ------------------------------------------------------------
	// field widths, ranges and reset values
	// ------------------------------------------------------------
	localparam int unsigned MSSQ_SEG_W  = 5;
	localparam int unsigned MSSQ_TIME_W = 16;

	localparam logic [15:0] MSSQ_RUN_MODE_RST  = 16'h0000;
	localparam logic [15:0] MSSQ_RUN_MODE_MAX  = 16'h0002;
	localparam logic [4:0]  MSSQ_LAST_SEG_RST  = 5'h01;
	localparam logic [4:0]  MSSQ_LAST_SEG_MIN  = 5'h01;
	localparam logic [4:0]  MSSQ_LAST_SEG_MAX  = 5'h10;
	localparam logic [4:0]  MSSQ_FIRST_SEG     = 5'h01;
	localparam logic        MSSQ_RESUME_RST    = 1'b0;
	localparam logic        MSSQ_TIME_UNIT_RST = 1'b0;
	localparam logic [15:0] MSSQ_TIME_RST      = 16'h0000;
	localparam logic [31:0] MSSQ_READ_NONE     = 32'h0000_0000;

	// status bit positions
	localparam int unsigned MSSQ_ST_SEG_LSB = 0;
	localparam int unsigned MSSQ_ST_STATE   = 8;
	localparam int unsigned MSSQ_ST_DONE    = 12;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int unsigned MSSQ_CLK_HZ       = 20_000_000;
	localparam int unsigned MSSQ_TICK_MS      = 1;
	localparam int unsigned MSSQ_CYC_PER_MS   = MSSQ_CLK_HZ / 1000 * MSSQ_TICK_MS;
	localparam logic [15:0] MSSQ_MS_PER_S     = 16'd1000;
	localparam int unsigned MSSQ_PRE_W        = 15;

	// ------------------------------------------------------------
	// enumerations
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		MSSQ_MODE_SINGLE,
		MSSQ_MODE_LOOP,
		MSSQ_MODE_SELECT
	} mssq_mode_type;

	typedef enum logic [2:0] {
		MSSQ_IDLE,
		MSSQ_ACCEL,
		MSSQ_MOVE,
		MSSQ_DECEL,
		MSSQ_WAIT,
		MSSQ_PAUSE,
		MSSQ_DONE
	} mssq_state_type;

endpackage

/* File: hdl/mssq_timer_if.sv */
/*
 * interface carrying one interval timer's load and expiry between the
 * sequencer and its timer. assumes one clock for both ends.
 */
`timescale 1ns/100ps
`default_nettype none

interface mssq_timer_if;
	logic        load;
	logic [15:0] count;
	logic        run;
	logic        expired;

	modport ctrl (output load, output count, output run, input expired);
	modport timer (input load, input count, input run, output expired);
endinterface

`default_nettype wire

/* File: hdl/mssq_timer.sv */
/*
 * interval timer counting whole milliseconds or seconds on a 1 ms tick.
 * assumes a synchronous active-high reset and the 20 MHz clock.
 */
`timescale 1ns/100ps
`default_nettype none

module mssq_timer
	import mssq_pkg::*;
(
	// clock and reset
	input  wire logic  clk_in,
	input  wire logic  rst_in,
	// configuration
	input  wire logic  unit_s_in,
	// control
	mssq_timer_if.timer tif
);

	typedef struct packed {
		logic [MSSQ_PRE_W-1:0] pre;
		logic [15:0]           ms;
		logic [15:0]           left;
		logic                  expired;
	} mssq_tmr_type;

	mssq_tmr_type s_q;
	mssq_tmr_type s_d;

	// ------------------------------------------------------------
	// tick divider and countdown
	// ------------------------------------------------------------
	always_comb begin
		s_d = s_q;
		s_d.expired = 1'b0;
		if (tif.load) begin
			s_d.pre = '0;
			s_d.ms = '0;
			s_d.left = tif.count;
			s_d.expired = (tif.count == 16'h0000);
		end else if (tif.run && s_q.left != 16'h0000) begin
			if (s_q.pre == MSSQ_PRE_W'(MSSQ_CYC_PER_MS - 1)) begin
				s_d.pre = '0;
				if (!unit_s_in || s_q.ms == MSSQ_MS_PER_S - 16'd1) begin
					s_d.ms = '0;
					s_d.left = s_q.left - 16'd1;
					s_d.expired = (s_q.left == 16'd1);
				end else begin
					s_d.ms = s_q.ms + 16'd1;
				end
			end else begin
				s_d.pre = s_q.pre + MSSQ_PRE_W'(1);
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign tif.expired = s_q.expired;

endmodule

`default_nettype wire

/* File: hdl/mssq_top.sv */
/*
 * multi-segment position sequencer: steps a drive through stored position
 * segments in single-pass, looping or input-selected mode, with acceleration,
 * deceleration and inter-segment waiting times shared by all segments.
 * assumes inputs synchronous to CLK_IN, an avalon-mm master, and a motion
 * generator that pulses SEG_DONE_IN when a segment's cruise part is finished.
 */
`timescale 1ns/100ps
`default_nettype none

module mssq_top
	import mssq_pkg::*;
(
	// clock and reset
	input  wire logic        CLK_IN,
	input  wire logic        SYS_RST_IN,
	// avalon-mm slave
	input  wire logic [7:0]  AVS_ADDRESS_IN,
	input  wire logic        AVS_READ_IN,
	input  wire logic        AVS_WRITE_IN,
	input  wire logic [31:0] AVS_WRITEDATA_IN,
	input  wire logic [3:0]  AVS_BYTEENABLE_IN,
	output logic [31:0]      AVS_READDATA_OUT,
	output logic             AVS_WAITREQUEST_OUT,
	// digital inputs
	input  wire logic        SEQUENCE_ENABLE_IN,
	input  wire logic        SEGMENT_SELECT_0_IN,
	input  wire logic        SEGMENT_SELECT_1_IN,
	input  wire logic        SEGMENT_SELECT_2_IN,
	input  wire logic        SEGMENT_SELECT_3_IN,
	input  wire logic        MULTI_SEG_MODE_IN,
	// motion generator
	input  wire logic        SEG_DONE_IN,
	output logic [4:0]       SEGMENT_OUT,
	output logic             SEG_START_OUT,
	output logic             MOTION_RUN_OUT,
	output logic             ACCEL_PHASE_OUT,
	output logic             DECEL_PHASE_OUT,
	output logic             SEQ_DONE_OUT
);

	typedef struct packed {
		logic [15:0]    run_mode;
		logic [4:0]     last_seg;
		logic           resume;
		logic           unit_s;
		logic [15:0]    wait_t;
		logic [15:0]    accel_t;
		logic [15:0]    decel_t;
		logic [31:0]    rdata;
		logic           ack;
		mssq_state_type state;
		mssq_state_type paused_from;
		logic [4:0]     seg;
		logic           en_prev;
		logic           start;
		logic           done;
		logic           load;
		logic [15:0]    load_cnt;
		logic           wait_req;
		logic           run;
		logic           accel_ph;
		logic           decel_ph;
	} mssq_top_type;

	mssq_top_type s_q;
	mssq_top_type s_d;

	mssq_timer_if tif ();

	logic [4:0] sel_seg;
	logic       gate_en;
	logic       en_rise;
	logic       en_fall;
	logic       req;
	logic [31:0] wmask;
	logic [31:0] wr_word;
	logic [31:0] cur_word;

	mssq_timer u_timer (
		.clk_in    (CLK_IN),
		.rst_in    (SYS_RST_IN),
		.unit_s_in (s_q.unit_s),
		.tif       (tif)
	);

	assign tif.load  = s_q.load;
	assign tif.count = s_q.load_cnt;
	assign tif.run   = (s_q.state == MSSQ_ACCEL) || (s_q.state == MSSQ_DECEL) || (s_q.state == MSSQ_WAIT);

	// ------------------------------------------------------------
	// input decode
	// ------------------------------------------------------------
	assign sel_seg = {1'b0, SEGMENT_SELECT_3_IN, SEGMENT_SELECT_2_IN, SEGMENT_SELECT_1_IN, SEGMENT_SELECT_0_IN}
		+ 5'h01;
	assign gate_en = SEQUENCE_ENABLE_IN && MULTI_SEG_MODE_IN;
	assign en_rise = gate_en && !s_q.en_prev;
	assign en_fall = !gate_en && s_q.en_prev;
	assign req     = (AVS_READ_IN || AVS_WRITE_IN) && !s_q.ack;
	assign wmask   = {{8{AVS_BYTEENABLE_IN[3]}}, {8{AVS_BYTEENABLE_IN[2]}},
		{8{AVS_BYTEENABLE_IN[1]}}, {8{AVS_BYTEENABLE_IN[0]}}};

	// ------------------------------------------------------------
	// register read mux
	// ------------------------------------------------------------
	always_comb begin
		case (AVS_ADDRESS_IN)
			MSSQ_ADDR_RUN_MODE:  cur_word = {16'h0000, s_q.run_mode};
			MSSQ_ADDR_LAST_SEG:  cur_word = {27'h000_0000, s_q.last_seg};
			MSSQ_ADDR_RESUME:    cur_word = {31'h0000_0000, s_q.resume};
			MSSQ_ADDR_TIME_UNIT: cur_word = {31'h0000_0000, s_q.unit_s};
			MSSQ_ADDR_WAIT:      cur_word = {16'h0000, s_q.wait_t};
			MSSQ_ADDR_ACCEL:     cur_word = {16'h0000, s_q.accel_t};
			MSSQ_ADDR_DECEL:     cur_word = {16'h0000, s_q.decel_t};
			MSSQ_ADDR_STATUS: begin
				cur_word = MSSQ_READ_NONE;
				cur_word[MSSQ_ST_SEG_LSB +: 5] = s_q.seg;
				cur_word[MSSQ_ST_STATE +: 3] = s_q.state;
				cur_word[MSSQ_ST_DONE] = s_q.done;
			end
			default:             cur_word = MSSQ_READ_NONE;
		endcase
		wr_word = (cur_word & ~wmask) | (AVS_WRITEDATA_IN & wmask);
	end

	// ------------------------------------------------------------
	// bus slave and sequencer
	// ------------------------------------------------------------
	always_comb begin
		s_d = s_q;
		s_d.ack = req;
		s_d.wait_req = !req;
		s_d.start = 1'b0;
		s_d.load = 1'b0;
		s_d.en_prev = gate_en;

		if (req && AVS_READ_IN) begin
			s_d.rdata = cur_word;
		end
		// commit at the edge where the master sees waitrequest low
		if (s_q.ack && AVS_WRITE_IN) begin
			case (AVS_ADDRESS_IN)
				MSSQ_ADDR_RUN_MODE: begin
					if (wr_word[15:0] <= MSSQ_RUN_MODE_MAX) begin
						s_d.run_mode = wr_word[15:0];
					end
				end
				MSSQ_ADDR_LAST_SEG: begin
					if (wr_word[31:0] >= 32'(MSSQ_LAST_SEG_MIN) && wr_word[31:0] <= 32'(MSSQ_LAST_SEG_MAX)) begin
						s_d.last_seg = wr_word[4:0];
					end
				end
				MSSQ_ADDR_RESUME:    s_d.resume = wr_word[0];
				MSSQ_ADDR_TIME_UNIT: s_d.unit_s = wr_word[0];
				MSSQ_ADDR_WAIT:      s_d.wait_t = wr_word[15:0];
				MSSQ_ADDR_ACCEL:     s_d.accel_t = wr_word[15:0];
				MSSQ_ADDR_DECEL:     s_d.decel_t = wr_word[15:0];
				default: begin
				end
			endcase
		end

		case (s_q.state)
			MSSQ_IDLE, MSSQ_DONE: begin
				if (en_rise) begin
					s_d.done = 1'b0;
					s_d.state = MSSQ_ACCEL;
					s_d.start = 1'b1;
					s_d.load = 1'b1;
					s_d.load_cnt = s_q.accel_t;
					if (s_q.run_mode == 16'(MSSQ_MODE_SELECT)) begin
						s_d.seg = sel_seg;
					end else begin
						s_d.seg = MSSQ_FIRST_SEG;
					end
				end
			end
			MSSQ_ACCEL, MSSQ_MOVE, MSSQ_DECEL, MSSQ_WAIT: begin
				if (en_fall) begin
					s_d.paused_from = s_q.state;
					s_d.state = MSSQ_PAUSE;
				end else begin
					case (s_q.state)
						MSSQ_ACCEL: begin
							if (tif.expired) begin
								s_d.state = MSSQ_MOVE;
							end
						end
						MSSQ_MOVE: begin
							if (SEG_DONE_IN) begin
								s_d.state = MSSQ_DECEL;
								s_d.load = 1'b1;
								s_d.load_cnt = s_q.decel_t;
							end
						end
						MSSQ_DECEL: begin
							if (tif.expired) begin
								if (s_q.run_mode == 16'(MSSQ_MODE_SELECT)) begin
									s_d.state = MSSQ_DONE;
									s_d.done = 1'b1;
								end else if (s_q.seg >= s_q.last_seg
									&& s_q.run_mode == 16'(MSSQ_MODE_SINGLE)) begin
									s_d.state = MSSQ_DONE;
									s_d.done = 1'b1;
								end else begin
									s_d.state = MSSQ_WAIT;
									s_d.load = 1'b1;
									s_d.load_cnt = s_q.wait_t;
								end
							end
						end
						default: begin
							if (tif.expired) begin
								if (s_q.seg >= s_q.last_seg) begin
									s_d.seg = MSSQ_FIRST_SEG;
								end else begin
									s_d.seg = s_q.seg + 5'h01;
								end
								s_d.state = MSSQ_ACCEL;
								s_d.start = 1'b1;
								s_d.load = 1'b1;
								s_d.load_cnt = s_q.accel_t;
							end
						end
					endcase
				end
			end
			MSSQ_PAUSE: begin
				if (en_rise) begin
					s_d.start = 1'b1;
					s_d.state = MSSQ_ACCEL;
					s_d.load = 1'b1;
					s_d.load_cnt = s_q.accel_t;
					if (s_q.resume) begin
						if (s_q.run_mode == 16'(MSSQ_MODE_SELECT)) begin
							s_d.seg = sel_seg;
						end else begin
							s_d.seg = MSSQ_FIRST_SEG;
						end
					end else if (s_q.paused_from == MSSQ_WAIT) begin
						if (s_q.seg >= s_q.last_seg) begin
							s_d.seg = MSSQ_FIRST_SEG;
						end else begin
							s_d.seg = s_q.seg + 5'h01;
						end
					end
				end
			end
			default: s_d.state = MSSQ_IDLE;
		endcase
		s_d.run = (s_d.state == MSSQ_ACCEL) || (s_d.state == MSSQ_MOVE) || (s_d.state == MSSQ_DECEL);
		s_d.accel_ph = (s_d.state == MSSQ_ACCEL);
		s_d.decel_ph = (s_d.state == MSSQ_DECEL);
	end

	always_ff @(posedge CLK_IN) begin
		if (SYS_RST_IN) begin
			s_q <= '0;
			s_q.wait_req <= 1'b1;
			s_q.run_mode <= MSSQ_RUN_MODE_RST;
			s_q.last_seg <= MSSQ_LAST_SEG_RST;
			s_q.resume <= MSSQ_RESUME_RST;
			s_q.unit_s <= MSSQ_TIME_UNIT_RST;
			s_q.wait_t <= MSSQ_TIME_RST;
			s_q.accel_t <= MSSQ_TIME_RST;
			s_q.decel_t <= MSSQ_TIME_RST;
			s_q.state <= MSSQ_IDLE;
			s_q.paused_from <= MSSQ_IDLE;
			s_q.seg <= MSSQ_FIRST_SEG;
		end else begin
			s_q <= s_d;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign AVS_READDATA_OUT    = s_q.rdata;
	assign AVS_WAITREQUEST_OUT = s_q.wait_req;
	assign SEGMENT_OUT         = s_q.seg;
	assign SEG_START_OUT       = s_q.start;
	assign SEQ_DONE_OUT        = s_q.done;
	assign MOTION_RUN_OUT      = s_q.run;
	assign ACCEL_PHASE_OUT     = s_q.accel_ph;
	assign DECEL_PHASE_OUT     = s_q.decel_ph;

endmodule

`default_nettype wire

/* File: tb/mssq_chk.sv */
/* checker for the sequencer top ports.
 * assumes one clock and a synchronous active-high reset. */
`timescale 1ns/100ps
`default_nettype none

module mssq_chk (
	// clock and reset
	input wire logic       CLK_IN,
	input wire logic       SYS_RST_IN,
	// bus
	input wire logic       AVS_READ_IN,
	input wire logic       AVS_WRITE_IN,
	input wire logic       AVS_WAITREQUEST_OUT,
	// sequencer
	input wire logic       SEQUENCE_ENABLE_IN,
	input wire logic       MULTI_SEG_MODE_IN,
	input wire logic [4:0] SEGMENT_OUT,
	input wire logic       SEG_START_OUT,
	input wire logic       MOTION_RUN_OUT,
	input wire logic       ACCEL_PHASE_OUT,
	input wire logic       DECEL_PHASE_OUT,
	input wire logic       SEQ_DONE_OUT
);
	default clocking @(posedge CLK_IN); endclocking
	default disable iff (SYS_RST_IN);
	property p_start_accel; SEG_START_OUT |-> ACCEL_PHASE_OUT && MOTION_RUN_OUT; endproperty
	a_start_accel: assert property (p_start_accel) else $error("start without accel");
	property p_start_pulse; SEG_START_OUT |=> !SEG_START_OUT; endproperty
	a_start_pulse: assert property (p_start_pulse) else $error("start longer than one cycle");
	property p_start_gated; SEG_START_OUT |-> $past(SEQUENCE_ENABLE_IN) && $past(MULTI_SEG_MODE_IN); endproperty
	a_start_gated: assert property (p_start_gated) else $error("start while gated");
	property p_phase; (ACCEL_PHASE_OUT || DECEL_PHASE_OUT) |-> MOTION_RUN_OUT && !(ACCEL_PHASE_OUT && DECEL_PHASE_OUT);
	endproperty
	a_phase: assert property (p_phase) else $error("phase outputs inconsistent");
	property p_seg_range; SEGMENT_OUT >= 5'h01 && SEGMENT_OUT <= 5'h10; endproperty
	a_seg_range: assert property (p_seg_range) else $error("segment out of range");
	property p_pause; $fell(SEQUENCE_ENABLE_IN) |-> ##[1:4] !MOTION_RUN_OUT; endproperty
	a_pause: assert property (p_pause) else $error("no pause on enable off");
	property p_done_stop; SEQ_DONE_OUT |-> !MOTION_RUN_OUT && !SEG_START_OUT; endproperty
	a_done_stop: assert property (p_done_stop) else $error("motion after stop");
	property p_seg_hold; MOTION_RUN_OUT && $past(MOTION_RUN_OUT) |-> $stable(SEGMENT_OUT); endproperty
	a_seg_hold: assert property (p_seg_hold) else $error("segment changed while running");
	property p_ack_one; !AVS_WAITREQUEST_OUT |=> AVS_WAITREQUEST_OUT; endproperty
	a_ack_one: assert property (p_ack_one) else $error("ack longer than one cycle");
	property p_ack_cause; !AVS_WAITREQUEST_OUT |-> $past(AVS_READ_IN || AVS_WRITE_IN); endproperty
	a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
endmodule

bind mssq_top mssq_chk u_chk (.CLK_IN(CLK_IN), .SYS_RST_IN(SYS_RST_IN), .AVS_READ_IN(AVS_READ_IN),
	.AVS_WRITE_IN(AVS_WRITE_IN), .AVS_WAITREQUEST_OUT(AVS_WAITREQUEST_OUT),
	.SEQUENCE_ENABLE_IN(SEQUENCE_ENABLE_IN), .MULTI_SEG_MODE_IN(MULTI_SEG_MODE_IN),
	.SEGMENT_OUT(SEGMENT_OUT), .SEG_START_OUT(SEG_START_OUT), .MOTION_RUN_OUT(MOTION_RUN_OUT),
	.ACCEL_PHASE_OUT(ACCEL_PHASE_OUT), .DECEL_PHASE_OUT(DECEL_PHASE_OUT), .SEQ_DONE_OUT(SEQ_DONE_OUT));

`default_nettype wire

/* File: tb/mssq_motion_model.sv */
/* motion generator model: pulses segment done after a set cruise time.
 * assumes run and phase levels from the sequencer. */
`timescale 1ns/100ps
`default_nettype none

module mssq_motion_model (
	// clock and reset
	input  wire logic        clk_in,
	input  wire logic        rst_in,
	// sequencer side
	input  wire logic        run_in,
	input  wire logic        accel_in,
	input  wire logic        decel_in,
	input  wire logic [15:0] delay_in,
	output logic             seg_done_out
);
	logic [15:0] cnt_q;
	// cruise counts only while neither phase is active
	always_ff @(posedge clk_in) begin
		if (rst_in || !(run_in && !accel_in && !decel_in)) begin
			cnt_q        <= 16'h0000;
			seg_done_out <= 1'b0;
		end else begin
			cnt_q        <= cnt_q + 16'h0001;
			seg_done_out <= (cnt_q == delay_in);
		end
	end
endmodule

`default_nettype wire

/* File: tb/tb_mssq_top.sv */
/* self-checking bench for the sequencer.
 * assumes the motion model as far side and a 20 MHz clock. */
`timescale 1ns/100ps
`default_nettype none

module tb_mssq_top;
	import mssq_pkg::*;
	logic clk, rst, rd, wr, en, multi, sdin, wreq, start, run, acc, dec, sdone;
	logic [7:0]  addr;
	logic [31:0] wdata, rdat, r;
	logic [3:0]  sel, v;
	logic [4:0]  seg;
	logic [15:0] mv_delay;
	int err_total, check_count, seed, acc_n, last_acc, idle_n, gap;
	int exp_q[$];

	mssq_top uut (.CLK_IN(clk), .SYS_RST_IN(rst), .AVS_ADDRESS_IN(addr), .AVS_READ_IN(rd), .AVS_WRITE_IN(wr),
		.AVS_WRITEDATA_IN(wdata), .AVS_BYTEENABLE_IN(4'hF), .AVS_READDATA_OUT(rdat), .AVS_WAITREQUEST_OUT(wreq),
		.SEQUENCE_ENABLE_IN(en), .SEGMENT_SELECT_0_IN(sel[0]), .SEGMENT_SELECT_1_IN(sel[1]),
		.SEGMENT_SELECT_2_IN(sel[2]), .SEGMENT_SELECT_3_IN(sel[3]), .MULTI_SEG_MODE_IN(multi),
		.SEG_DONE_IN(sdin), .SEGMENT_OUT(seg), .SEG_START_OUT(start), .MOTION_RUN_OUT(run),
		.ACCEL_PHASE_OUT(acc), .DECEL_PHASE_OUT(dec), .SEQ_DONE_OUT(sdone));
	mssq_motion_model u_mot (.clk_in(clk), .rst_in(rst), .run_in(run), .accel_in(acc), .decel_in(dec),
		.delay_in(mv_delay), .seg_done_out(sdin));

	task check(input string nm, input logic [31:0] seen, input logic [31:0] expv);
		check_count++;
		if (seen !== expv) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", nm, expv, seen);
		end
	endtask
	task tally_and_finish;
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		rd <= !w; wr <= w; addr <= a; wdata <= d;
		do begin @(posedge clk); n++; end while (wreq !== 1'b0);
		check("bus wait states", n, 2);
		r = rdat;
		rd <= 1'b0; wr <= 1'b0;
	endtask
	task set_en(input logic e);
		@(posedge clk);
		en <= e;
		repeat (3) @(posedge clk);
	endtask
	task drain;
		int n;
		n = 0;
		while (exp_q.size() != 0 && n < 70000) begin @(posedge clk); n++; end
		check("pending starts", exp_q.size(), 0);
	endtask
	task wait_done;
		int n;
		n = 0;
		while (sdone !== 1'b1 && n < 30000) begin @(posedge clk); n++; end
		check("seq done", sdone, 1'b1);
	endtask

	// --------------------------------------------------------
	// reference model: expected segment at every start
	// --------------------------------------------------------
	always @(posedge clk) begin
		if (start === 1'b1) begin
			gap = idle_n;
			if (exp_q.size() == 0) check("unexpected start", seg, 0);
			else check("segment", seg, exp_q.pop_front());
		end
		idle_n = (run === 1'b1) ? 0 : idle_n + 1;
		if (acc === 1'b1) acc_n++;
		else if (acc_n != 0) begin last_acc = acc_n; acc_n = 0; end
	end

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	initial begin
		repeat (90000) @(posedge clk);
		err_total++;
		tally_and_finish;
	end

	initial begin
		rst = 1; rd = 0; wr = 0; en = 0; multi = 1; sel = 0; addr = 0; wdata = 0; mv_delay = 16'd40;
		seed = 30217; idle_n = 0; acc_n = 0; last_acc = 0; gap = 0; err_total = 0; check_count = 0;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		bus(0, MSSQ_ADDR_RUN_MODE, 0); check("run mode rst", r, 32'h0000_0000);
		bus(0, MSSQ_ADDR_LAST_SEG, 0); check("last seg rst", r, 32'h0000_0001);
		bus(0, MSSQ_ADDR_RESUME, 0); check("resume rst", r, 32'h0000_0000);
		bus(0, 8'h20, 0); check("unmapped", r, MSSQ_READ_NONE);
		for (int m = 3; m >= 0; m--) begin
			bus(1, MSSQ_ADDR_RUN_MODE, m); bus(0, MSSQ_ADDR_RUN_MODE, 0);
			check("run mode", r, (m == 3) ? 32'h0000_0000 : m);
		end
		bus(1, MSSQ_ADDR_LAST_SEG, 0); bus(1, MSSQ_ADDR_LAST_SEG, 17); bus(0, MSSQ_ADDR_LAST_SEG, 0);
		check("last seg range", r, 32'h0000_0001);
		bus(1, MSSQ_ADDR_DECEL, 32'h0000_0003); bus(0, MSSQ_ADDR_DECEL, 0);
		check("decel time", r, 32'h0000_0003);
		bus(1, MSSQ_ADDR_DECEL, 0);
		$display("test registers done");
		bus(1, MSSQ_ADDR_LAST_SEG, 3);
		repeat (2) begin
			exp_q = {1, 2, 3}; set_en(1); drain; wait_done;
			set_en(0);
		end
		@(posedge clk); multi <= 1'b0;
		set_en(1); repeat (20) @(posedge clk);
		check("gated run", run, 1'b0);
		set_en(0); @(posedge clk); multi <= 1'b1;
		$display("test single pass done");
		bus(1, MSSQ_ADDR_LAST_SEG, 2); bus(1, MSSQ_ADDR_RUN_MODE, 1);
		exp_q = {1, 2, 1, 2}; set_en(1); drain; set_en(0);
		check("paused", run, 1'b0);
		exp_q = {2}; set_en(1); drain; set_en(0);
		bus(1, MSSQ_ADDR_RESUME, 1); exp_q = {1}; set_en(1); drain; set_en(0);
		bus(1, MSSQ_ADDR_RESUME, 0);
		$display("test loop done");
		bus(1, MSSQ_ADDR_RUN_MODE, 2);
		for (int i = 0; i < 6; i++) begin
			v = (i == 0) ? 4'h0 : (i == 1) ? 4'hF : 4'($random(seed));
			@(posedge clk); sel <= v;
			exp_q = {int'(v) + 1}; set_en(1);
			@(posedge clk); sel <= ~v;
			repeat (2) @(posedge clk);
			check("latched segment", seg, {1'b0, v} + 5'h01);
			if (i == 2) begin
				set_en(0); check("select pause", run, 1'b0);
				exp_q = {int'(v) + 1}; set_en(1);
			end
			drain; wait_done; set_en(0);
		end
		$display("test select done");
		bus(1, MSSQ_ADDR_RUN_MODE, 0); bus(1, MSSQ_ADDR_ACCEL, 1); bus(1, MSSQ_ADDR_WAIT, 1);
		mv_delay <= 16'd5; exp_q = {1, 2}; set_en(1); drain;
		check("wait length", gap >= MSSQ_CYC_PER_MS && gap <= MSSQ_CYC_PER_MS + 6, 1'b1);
		wait_done;
		check("accel length", last_acc >= MSSQ_CYC_PER_MS && last_acc <= MSSQ_CYC_PER_MS + 4, 1'b1);
		// status: done bit 12, state code 6 (done), segment 2
		bus(0, MSSQ_ADDR_STATUS, 0); check("status", r, 32'h0000_1602);
		set_en(0);
		$display("test timing done");
		tally_and_finish;
	end
endmodule

`default_nettype wire
